// ==== rtl/eaa_pkg.sv ====
// Package: geometry, commands and timing for the emulated EEPROM array access block
package eaa_pkg;
  localparam int ROWS = 512;
  localparam int WORD_BYTES = 2;
  localparam int ROWS_PER_SECTOR = 2;
  localparam int ADDR_W = 10;
  localparam int ROW_W = 9;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Operation times in ns, converted to cycles at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 400;
  localparam int ERASE_TIME_NS = 800;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {
    EAA_CMD_PROGRAM = 2'h0,
    EAA_CMD_SECTOR_ERASE = 2'h1,
    EAA_CMD_MASS_ERASE = 2'h2,
    EAA_CMD_ERASE_VERIFY = 2'h3
  } eaa_cmd_e;
endpackage

// ==== rtl/eaa_timer.sv ====
// Operation duration counter: loads a count, pulses done when it expires
`timescale 1ns/1ps
module eaa_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic done
);
  if (CNT_W < 2) begin : g_bad_width
    $error("eaa_timer: counter width too small");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic run_reg;
  logic run_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done = 1'b0;
    if (load) begin
      cnt_next = count;
      run_next = 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= CNT_W'(1)) begin
        run_next = 1'b0;
        done = 1'b1;
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end
endmodule

// ==== rtl/eaa_array.sv ====
// Emulated EEPROM array: bus read path and command-driven program/erase engine
//
// Functional notes
// - Storage is 512 rows of one 2-byte word, 1K bytes in total.
// - Sector erase clears exactly two rows, four bytes.
// - Byte and aligned word reads return data after one bus cycle.
// - Misaligned word reads complete in two bus cycles.
// - Program and erase start only from the command port, never bus writes.
// - Two erases exist: single sector and whole array.
// - Erased bits read one; programmed bits read zero.
// - No array reads are served while program or erase runs.
// - Interrupt requests on command complete and command buffer empty.
// - Mass erase only with protection fully off, else protection violation.
`timescale 1ns/1ps
module eaa_array #(
  parameter int PROG_CNT = eaa_pkg::PROG_CYCLES,
  parameter int ERASE_CNT = eaa_pkg::ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic [eaa_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_word,
  output logic rd_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic [eaa_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic prot_open,
  output logic cmd_ready,
  output logic busy,
  output logic cmd_done,
  output logic buf_empty,
  output logic prot_viol,
  output logic verify_ok
);
  localparam int ROWS = eaa_pkg::ROWS;
  localparam int ROW_W = eaa_pkg::ROW_W;

  localparam int CNT_W = eaa_pkg::CNT_W;

  // Busy must stand at least two cycles, or a one-cycle operation slips past the hold-off
  if (PROG_CNT < 2 || ERASE_CNT < 2 || PROG_CNT >= (1 << CNT_W) ||
      ERASE_CNT >= (1 << CNT_W)) begin : g_bad_counts
    $error("eaa_array: operation counts out of range");
  end

  typedef enum logic [2:0] {
    EAA_IDLE = 3'b001,
    EAA_MIS2 = 3'b010,
    EAA_OPER = 3'b100
  } eaa_state_e;

  function automatic logic [ROW_W-1:0] row_of(input logic [eaa_pkg::ADDR_W-1:0] a);
    row_of = a[eaa_pkg::ADDR_W-1:1];
  endfunction

  // Storage, one word per row
  logic [15:0] mem_reg [ROWS];
  logic [15:0] mem_next [ROWS];
  eaa_state_e st_reg, st_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] mis_lo_reg, mis_lo_next;
  logic [ROW_W-1:0] mis_row_reg, mis_row_next;
  logic [1:0] op_reg, op_next;
  logic [ROW_W-1:0] op_row_reg, op_row_next;
  logic [15:0] op_data_reg, op_data_next;
  logic viol_reg, viol_next;
  logic vok_reg, vok_next;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic all_erased;

  eaa_timer #(.CNT_W(CNT_W)) eaa_timer_i (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  always_comb begin
    all_erased = 1'b1;
    for (int i = 0; i < ROWS; i++) begin
      if (mem_reg[i] != eaa_pkg::ERASED_WORD) begin
        all_erased = 1'b0;
      end
    end
  end

  assign busy = (st_reg == EAA_OPER);
  assign rd_ready = (st_reg == EAA_IDLE) && !cmd_valid;
  assign cmd_ready = (st_reg == EAA_IDLE);
  assign buf_empty = (st_reg != EAA_OPER);
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign prot_viol = viol_reg;
  assign verify_ok = vok_reg;

  always_comb begin
    st_next = st_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    mis_lo_next = mis_lo_reg;
    mis_row_next = mis_row_reg;
    op_next = op_reg;
    op_row_next = op_row_reg;
    op_data_next = op_data_reg;
    viol_next = viol_reg;
    vok_next = vok_reg;
    tmr_load = 1'b0;
    tmr_count = '0;
    cmd_done = 1'b0;
    for (int i = 0; i < ROWS; i++) begin
      mem_next[i] = mem_reg[i];
    end
    unique case (st_reg)
      EAA_IDLE: begin
        // Command port has priority; bus writes never reach the array
        if (cmd_valid) begin
          op_next = cmd_code;
          op_row_next = row_of(cmd_addr);
          op_data_next = cmd_data;
          viol_next = 1'b0;
          if (cmd_code == eaa_pkg::EAA_CMD_MASS_ERASE && !prot_open) begin
            viol_next = 1'b1;
            cmd_done = 1'b1;
          end else if (cmd_code == eaa_pkg::EAA_CMD_ERASE_VERIFY) begin
            vok_next = all_erased;
            cmd_done = 1'b1;
          end else begin
            tmr_load = 1'b1;
            tmr_count = (cmd_code == eaa_pkg::EAA_CMD_PROGRAM) ? CNT_W'(PROG_CNT) : CNT_W'(ERASE_CNT);
            st_next = EAA_OPER;
          end
        end else if (rd_req) begin
          if (rd_word && rd_addr[0]) begin
            // Odd word spans two rows: low byte now, high byte next cycle
            mis_lo_next = mem_reg[row_of(rd_addr)][7:0];
            mis_row_next = row_of(rd_addr) + ROW_W'(1);
            st_next = EAA_MIS2;
          end else if (rd_word) begin
            rd_data_next = mem_reg[row_of(rd_addr)];
            rd_valid_next = 1'b1;
          end else begin
            rd_data_next = rd_addr[0] ? {8'h00, mem_reg[row_of(rd_addr)][7:0]} :
                                        {8'h00, mem_reg[row_of(rd_addr)][15:8]};
            rd_valid_next = 1'b1;
          end
        end
      end
      EAA_MIS2: begin
        rd_data_next = {mis_lo_reg, mem_reg[mis_row_reg][15:8]};
        rd_valid_next = 1'b1;
        st_next = EAA_IDLE;
      end
      EAA_OPER: begin
        if (tmr_done) begin
          unique case (op_reg)
            eaa_pkg::EAA_CMD_PROGRAM: begin
              // Program only clears bits
              mem_next[op_row_reg] = mem_reg[op_row_reg] & op_data_reg;
            end
            eaa_pkg::EAA_CMD_SECTOR_ERASE: begin
              mem_next[{op_row_reg[ROW_W-1:1], 1'b0}] = eaa_pkg::ERASED_WORD;
              mem_next[{op_row_reg[ROW_W-1:1], 1'b1}] = eaa_pkg::ERASED_WORD;
            end
            default: begin
              for (int i = 0; i < ROWS; i++) begin
                mem_next[i] = eaa_pkg::ERASED_WORD;
              end
            end
          endcase
          cmd_done = 1'b1;
          st_next = EAA_IDLE;
        end
      end
      default: st_next = EAA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= EAA_IDLE;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
      mis_lo_reg <= '0;
      mis_row_reg <= '0;
      op_reg <= '0;
      op_row_reg <= '0;
      op_data_reg <= '0;
      viol_reg <= 1'b0;
      vok_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      mis_lo_reg <= mis_lo_next;
      mis_row_reg <= mis_row_next;
      op_reg <= op_next;
      op_row_reg <= op_row_next;
      op_data_reg <= op_data_next;
      viol_reg <= viol_next;
      vok_reg <= vok_next;
    end
  end

  // Array contents survive reset, as nonvolatile storage should
  always_ff @(posedge clk) begin
    for (int i = 0; i < ROWS; i++) begin
      mem_reg[i] <= mem_next[i];
    end
  end

  a_aligned_read_lat: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_req && rd_ready && !(rd_word && rd_addr[0])) |=> rd_valid)
    else $error("aligned read not answered in one cycle");
  a_misaligned_read_lat: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_req && rd_ready && rd_word && rd_addr[0]) |=> !rd_valid ##1 rd_valid)
    else $error("misaligned read not answered in two cycles");
  a_no_read_busy: assert property (@(posedge clk) disable iff (!rst_n)
    busy |-> !rd_ready ##1 !rd_valid)
    else $error("read served while busy");
  a_busy_after_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && cmd_ready && cmd_code == eaa_pkg::EAA_CMD_PROGRAM) |=> busy)
    else $error("busy not raised after program command");
  a_busy_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && cmd_ready && cmd_code == eaa_pkg::EAA_CMD_PROGRAM) |=> busy [*2])
    else $error("busy dropped early");
  a_done_ends_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && cmd_done) |=> !busy && buf_empty)
    else $error("done did not end operation");
  a_mass_prot: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && cmd_ready && cmd_code == eaa_pkg::EAA_CMD_MASS_ERASE && !prot_open)
    |=> prot_viol && !busy)
    else $error("protected mass erase not rejected");
  a_cmd_starts_only: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> $past(cmd_valid && cmd_ready))
    else $error("operation started without command");
  a_prog_clears_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && cmd_done && op_reg == eaa_pkg::EAA_CMD_PROGRAM)
    |=> (mem_reg[$past(op_row_reg)] & ~$past(mem_reg[op_row_reg])) == 16'h0000)
    else $error("program set a bit");
endmodule

// ==== sim/eaa_host.sv ====
// Host model that issues commands on the command port
`timescale 1ns/1ps
module eaa_host (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  output logic cmd_valid,
  output logic [1:0] cmd_code,
  output logic [9:0] cmd_addr,
  output logic [15:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 2'h0;
    cmd_addr = 10'h000;
    cmd_data = 16'h0000;
  end
  // Bench only programs erased rows, each once; one command at a time
  task automatic send(input logic [1:0] c, input logic [9:0] a, input logic [15:0] d, output int lat);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    #1;
    while (!cmd_ready && n < 200) begin
      @(negedge clk);
      #1;
      n++;
    end
    lat = cmd_done ? 0 : 1;
    @(negedge clk);
    // Released address and data show garbage, not the old value
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_data = ~d;
    while (lat > 0 && !cmd_done && lat < 200) begin
      @(negedge clk);
      lat++;
    end
  endtask
endmodule

// ==== sim/eaa_array_tb.sv ====
// Testbench for the array access block
`timescale 1ns/1ps
module eaa_array_tb;
  localparam int PN = 4;
  localparam int EN = 6;
  localparam logic [1:0] PRG = eaa_pkg::EAA_CMD_PROGRAM;
  localparam logic [1:0] SEC = eaa_pkg::EAA_CMD_SECTOR_ERASE;
  localparam logic [1:0] MAS = eaa_pkg::EAA_CMD_MASS_ERASE;
  localparam logic [1:0] VER = eaa_pkg::EAA_CMD_ERASE_VERIFY;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_req = 1'b0;
  logic [9:0] rd_addr = 10'h000;
  logic rd_word = 1'b0;
  logic prot_open = 1'b0;
  logic rd_ready, rd_valid, cmd_valid, cmd_ready, busy, cmd_done, buf_empty, prot_viol, verify_ok;
  logic [15:0] rd_data, cmd_data;
  logic [1:0] cmd_code;
  logic [9:0] cmd_addr;
  int n_errors = 0;
  int checks = 0;
  int lat;
  always #5 clk = ~clk;
  eaa_array #(.PROG_CNT(PN), .ERASE_CNT(EN)) eaa_array_i (.clk(clk), .rst_n(rst_n), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_word(rd_word), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .prot_open(prot_open), .cmd_ready(cmd_ready), .busy(busy), .cmd_done(cmd_done),
    .buf_empty(buf_empty), .prot_viol(prot_viol), .verify_ok(verify_ok));
  eaa_host eaa_host_i (.clk(clk), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmd(input logic [1:0] c, input logic [9:0] a, input logic [15:0] d, input int el);
    eaa_host_i.send(c, a, d, lat);
    check("command latency", 16'(lat), 16'(el));
  endtask
  task automatic rd(input logic [9:0] a, input logic w, input logic [15:0] exp, input int el);
    int n;
    n = 0;
    @(negedge clk);
    rd_req = 1'b1;
    rd_addr = a;
    rd_word = w;
    #1;
    while (!rd_ready && n < 50) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    rd_req = 1'b0;
    rd_addr = ~a;
    n = 1;
    while (!rd_valid && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("read data", rd_data, exp);
    check("read latency", 16'(n), 16'(el));
  endtask
  // Reads during an operation must be held off, not answered late
  task automatic rd_blocked(input logic [9:0] a);
    // Second negedge: the command is taken in between, so busy already stands
    repeat (2) @(negedge clk);
    rd_req = 1'b1;
    rd_addr = a;
    rd_word = 1'b1;
    repeat (2) begin
      #1;
      check("busy", {15'h0, busy}, 16'h0001);
      check("buffer empty", {15'h0, buf_empty}, 16'h0000);
      check("read taken", {15'h0, rd_ready}, 16'h0000);
      @(negedge clk);
      check("read answer", {15'h0, rd_valid}, 16'h0000);
    end
    rd_req = 1'b0;
  endtask
  task automatic t_mass;
    cmd(MAS, 10'h000, 16'h0000, 0);
    check("protection flag", {15'h0, prot_viol}, 16'h0001);
    prot_open = 1'b1;
    fork
      cmd(MAS, 10'h000, 16'h0000, EN);
      rd_blocked(10'h010);
    join
    check("protection flag", {15'h0, prot_viol}, 16'h0000);
    cmd(VER, 10'h000, 16'h0000, 0);
    check("verify", {15'h0, verify_ok}, 16'h0001);
    rd(10'h3fe, 1'b1, 16'hffff, 1);
    $display("test mass erase done");
  endtask
  task automatic t_prog;
    fork
      cmd(PRG, 10'h00a, 16'h1234, PN);
      rd_blocked(10'h00a);
    join
    cmd(PRG, 10'h3fe, 16'h00c3, PN);
    cmd(PRG, 10'h000, 16'h6b00, PN);
    cmd(VER, 10'h000, 16'h0000, 0);
    check("verify", {15'h0, verify_ok}, 16'h0000);
    rd(10'h00a, 1'b1, 16'h1234, 1);
    rd(10'h00a, 1'b0, 16'h0012, 1);
    rd(10'h00b, 1'b1, 16'h34ff, 2);
    rd(10'h00b, 1'b0, 16'h0034, 1);
    rd(10'h3ff, 1'b1, 16'hc36b, 2);
    $display("test program and read done");
  endtask
  task automatic t_sector;
    cmd(PRG, 10'h008, 16'h0f0f, PN);
    cmd(PRG, 10'h00c, 16'habcd, PN);
    cmd(SEC, 10'h00a, 16'h0000, EN);
    rd(10'h008, 1'b1, 16'hffff, 1);
    rd(10'h00a, 1'b1, 16'hffff, 1);
    rd(10'h00c, 1'b1, 16'habcd, 1);
    rd(10'h000, 1'b1, 16'h6b00, 1);
    $display("test sector erase done");
  endtask
  // Mid-run reset clears status but leaves the array contents alone
  task automatic t_reset;
    prot_open = 1'b0;
    cmd(MAS, 10'h000, 16'h0000, 0);
    check("protection flag", {15'h0, prot_viol}, 16'h0001);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    #1;
    check("reset protection flag", {15'h0, prot_viol}, 16'h0000);
    check("reset read data", rd_data, 16'h0000);
    check("reset busy", {15'h0, busy}, 16'h0000);
    check("reset read answer", {15'h0, rd_valid}, 16'h0000);
    rd(10'h00c, 1'b1, 16'habcd, 1);
    rd(10'h3ff, 1'b1, 16'hc36b, 2);
    $display("test reset done");
  endtask
  initial begin
    #50000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    #1;
    check("idle busy", {15'h0, busy}, 16'h0000);
    check("idle ready", {15'h0, cmd_ready}, 16'h0001);
    t_mass();
    t_prog();
    t_sector();
    t_reset();
    end_of_test();
  end
endmodule
